// *** common/drct_pkg.sv ***
// Constants shared by the compressor timing control block
package drct_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_ENABLE = 10'h044;
  localparam logic [9:0] IDX_HOLD = 10'h045;
  localparam logic [9:0] IDX_RATE = 10'h046;
  localparam logic [9:0] IDX_STATUS = 10'h060;
  localparam logic [11:0] ADDR_ENABLE = {IDX_ENABLE, 2'b00};
  localparam logic [11:0] ADDR_HOLD = {IDX_HOLD, 2'b00};
  localparam logic [11:0] ADDR_RATE = {IDX_RATE, 2'b00};
  localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

  // Field positions
  localparam int EN_LEFT_BIT = 6;
  localparam int EN_RIGHT_BIT = 5;
  localparam int HOLD_LSB = 3;
  localparam int HOLD_MSB = 6;
  localparam int ATTACK_LSB = 4;
  localparam int ATTACK_MSB = 7;
  localparam int DECAY_LSB = 0;
  localparam int DECAY_MSB = 3;

  // Reset values
  localparam logic [3:0] HOLD_RST = 4'h7;
  localparam logic [3:0] ATTACK_RST = 4'h0;
  localparam logic [3:0] DECAY_RST = 4'h0;
  localparam logic EN_RST = 1'b0;

  // Hold lengths in DAC word clocks
  localparam int HOLD_W = 18;
  localparam logic [3:0] HOLD_OFF = 4'h0;
  localparam logic [3:0] HOLD_LAST_DOUBLING = 4'hB;
  localparam logic [3:0] HOLD_CODE_C = 4'hC;
  localparam logic [3:0] HOLD_CODE_D = 4'hD;
  localparam logic [HOLD_W-1:0] HOLD_BASE = 18'h00020;
  localparam logic [HOLD_W-1:0] HOLD_LEN_C = 18'h10000;
  localparam logic [HOLD_W-1:0] HOLD_LEN_D = 18'h18000;
  localparam logic [HOLD_W-1:0] HOLD_LEN_EF = 18'h28000;

  // Gain steps in dB, unsigned with 21 fraction bits
  localparam int STEP_W = 24;
  localparam logic [STEP_W-1:0] ATTACK_BASE_STEP = 24'h800000;
  localparam logic [STEP_W-1:0] DECAY_BASE_STEP = 24'h008000;
endpackage

// *** core/drct_hold_timer.sv ***
// Hold interval counter for one compressor channel
`timescale 1ns/1ns
module drct_hold_timer
  import drct_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic chan_en,
  input wire logic start,
  input wire logic sample_tick,
  input wire logic [HOLD_W-1:0] hold_len,
  // State
  output logic hold_active
);
  logic [HOLD_W-1:0] cnt_r;
  logic [HOLD_W-1:0] cnt_nxt;
  wire cnt_zero = (cnt_r == '0);
  wire cnt_dec = sample_tick && !cnt_zero;

  assign cnt_nxt = !chan_en ? '0 :
                   start ? hold_len :
                   cnt_dec ? cnt_r - 18'h00001 : cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      hold_active <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      hold_active <= (cnt_nxt != '0);
    end
  end
endmodule

// *** core/drct_timing_ctrl.sv ***
// Compressor hold, attack and decay timing control with APB registers
//
// Operation
// - Hold code zero off, one 32, doubling
// - Upper hold codes 65536, 98304, 163840
// - Hold code zero applies no hold
// - Attack code halves 4 dB step
// - Slowest attack code gives base over 2^15
// - Decay step 0.015625 dB over 2^code
// - Separate left and right compressor enables
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
module drct_timing_ctrl
  import drct_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // DAC word clock pin
  input wire logic word_clk,
  // Hold requests from gain computation
  input wire logic left_hold_start,
  input wire logic right_hold_start,
  // Timing outputs
  output logic left_comp_en,
  output logic right_comp_en,
  output logic left_hold_active,
  output logic right_hold_active,
  output logic [STEP_W-1:0] attack_step,
  output logic [STEP_W-1:0] decay_step,
  output logic sample_tick
);
  // Word clock synchroniser and edge detect
  logic wc_s1_r;
  logic wc_s2_r;
  logic wc_s3_r;
  wire tick = wc_s2_r && !wc_s3_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wc_s1_r <= 1'b0;
      wc_s2_r <= 1'b0;
      wc_s3_r <= 1'b0;
    end else begin
      wc_s1_r <= word_clk;
      wc_s2_r <= wc_s1_r;
      wc_s3_r <= wc_s2_r;
    end
  end

  // Registers
  logic left_en_r;
  logic right_en_r;
  logic [3:0] hold_code_r;
  logic [3:0] attack_code_r;
  logic [3:0] decay_code_r;

  // Bus decode
  wire setup = psel && !penable;
  wire commit = psel && penable && pready;
  wire hit_en = (paddr == ADDR_ENABLE);
  wire hit_hold = (paddr == ADDR_HOLD);
  wire hit_rate = (paddr == ADDR_RATE);
  wire hit_stat = (paddr == ADDR_STATUS);
  wire mapped = hit_en || hit_hold || hit_rate || hit_stat;
  // Status is read only, so a write there is refused too
  wire bad = !mapped || (pwrite && hit_stat);
  wire wr_ok = commit && pwrite && !pslverr && pstrb[0];
  wire [7:0] wb = pwdata[7:0];

  wire [7:0] rd_en = {1'b0, left_en_r, right_en_r, 5'h00};
  // Reserved bits are not stored, read zero
  wire [7:0] rd_hold = {1'b0, hold_code_r, 3'h0};
  wire [7:0] rd_rate = {attack_code_r, decay_code_r};
  wire [7:0] rd_stat = {5'h00, sample_tick, right_hold_active,
                        left_hold_active};
  wire [7:0] rd_byte = hit_en ? rd_en :
                       hit_hold ? rd_hold :
                       hit_rate ? rd_rate :
                       hit_stat ? rd_stat : 8'h00;

  // One wait-free access phase; answer is prepared in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup && bad;
      if (setup) begin
        prdata <= (pwrite || bad) ? 32'h00000000 : {24'h000000, rd_byte};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_en_r <= EN_RST;
      right_en_r <= EN_RST;
    end else if (wr_ok && hit_en) begin
      left_en_r <= wb[EN_LEFT_BIT];
      right_en_r <= wb[EN_RIGHT_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_code_r <= HOLD_RST;
    end else if (wr_ok && hit_hold) begin
      hold_code_r <= wb[HOLD_MSB:HOLD_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attack_code_r <= ATTACK_RST;
      decay_code_r <= DECAY_RST;
    end else if (wr_ok && hit_rate) begin
      attack_code_r <= wb[ATTACK_MSB:ATTACK_LSB];
      decay_code_r <= wb[DECAY_MSB:DECAY_LSB];
    end
  end

  // Hold length lookup
  // Off at zero, doubling from 32
  wire [3:0] hold_shift = hold_code_r - 4'h1;
  wire [HOLD_W-1:0] hold_len =
    (hold_code_r == HOLD_OFF) ? '0 :
    (hold_code_r <= HOLD_LAST_DOUBLING) ? HOLD_BASE << hold_shift :
    (hold_code_r == HOLD_CODE_C) ? HOLD_LEN_C :
    (hold_code_r == HOLD_CODE_D) ? HOLD_LEN_D : HOLD_LEN_EF;

  // Code 15 gives base over 2^15
  wire [STEP_W-1:0] attack_nxt = ATTACK_BASE_STEP >> attack_code_r;
  wire [STEP_W-1:0] decay_nxt = DECAY_BASE_STEP >> decay_code_r;

  // Steps change only at a word clock
  // Avoids a step changing in mid sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attack_step <= ATTACK_BASE_STEP;
      decay_step <= DECAY_BASE_STEP;
      sample_tick <= 1'b0;
      left_comp_en <= EN_RST;
      right_comp_en <= EN_RST;
    end else begin
      sample_tick <= tick;
      left_comp_en <= left_en_r;
      right_comp_en <= right_en_r;
      if (tick) begin
        attack_step <= attack_nxt;
        decay_step <= decay_nxt;
      end
    end
  end

  drct_hold_timer u_left_hold (
    .pclk(pclk),
    .presetn(presetn),
    .chan_en(left_en_r),
    .start(left_hold_start),
    .sample_tick(tick),
    .hold_len(hold_len),
    .hold_active(left_hold_active)
  );

  drct_hold_timer u_right_hold (
    .pclk(pclk),
    .presetn(presetn),
    .chan_en(right_en_r),
    .start(right_hold_start),
    .sample_tick(tick),
    .hold_len(hold_len),
    .hold_active(right_hold_active)
  );

  // Checks
  property p_hold_code_one;
    @(posedge pclk) disable iff (!presetn)
    (hold_code_r == 4'h1) |-> (hold_len == 18'h00020);
  endproperty
  a_hold_code_one: assert property (p_hold_code_one)
    else $error("hold code one is not 32 word clocks");

  property p_hold_doubling;
    @(posedge pclk) disable iff (!presetn)
    (hold_code_r == 4'hB) |-> (hold_len == 18'h08000);
  endproperty
  a_hold_doubling: assert property (p_hold_doubling)
    else $error("hold code 11 is not 32768 word clocks");

  property p_hold_upper;
    @(posedge pclk) disable iff (!presetn)
    (hold_code_r == 4'hC) |-> (hold_len == 18'h10000);
  endproperty
  a_hold_upper: assert property (p_hold_upper)
    else $error("hold code 12 is not 65536 word clocks");

  property p_hold_upper_d;
    @(posedge pclk) disable iff (!presetn)
    (hold_code_r == 4'hD) |-> (hold_len == 18'h18000);
  endproperty
  a_hold_upper_d: assert property (p_hold_upper_d)
    else $error("hold code 13 is not 98304 word clocks");

  property p_hold_off;
    @(posedge pclk) disable iff (!presetn)
    (hold_code_r == 4'h0 && left_hold_start && !left_hold_active)
      |=> !left_hold_active;
  endproperty
  a_hold_off: assert property (p_hold_off)
    else $error("hold started while hold is disabled");

  sequence s_hold_armed;
    left_en_r && left_hold_start && hold_code_r == 4'h1;
  endsequence

  sequence s_hold_kept;
    left_hold_active [*8];
  endsequence

  property p_hold_kept;
    @(posedge pclk) disable iff (!presetn)
    s_hold_armed |=> s_hold_kept;
  endproperty
  a_hold_kept: assert property (p_hold_kept)
    else $error("32 word clock hold ended too soon");

  property p_attack_fast;
    @(posedge pclk) disable iff (!presetn)
    (tick && attack_code_r == 4'h0) |=> (attack_step == 24'h800000);
  endproperty
  a_attack_fast: assert property (p_attack_fast)
    else $error("attack code zero is not 4 dB");

  property p_attack_slow;
    @(posedge pclk) disable iff (!presetn)
    (tick && attack_code_r == 4'hF) |=> (attack_step == 24'h000100);
  endproperty
  a_attack_slow: assert property (p_attack_slow)
    else $error("attack code 15 is not base over 2^15");

  property p_decay;
    @(posedge pclk) disable iff (!presetn)
    (tick && decay_code_r == 4'h3) |=> (decay_step == 24'h001000);
  endproperty
  a_decay: assert property (p_decay)
    else $error("decay code 3 is not base over 8");

  property p_chan_off;
    @(posedge pclk) disable iff (!presetn)
    !right_en_r |=> (!right_hold_active && !right_comp_en);
  endproperty
  a_chan_off: assert property (p_chan_off)
    else $error("disabled channel still holds or is enabled");

  property p_step_steady;
    @(posedge pclk) disable iff (!presetn)
    !tick |=> ($stable(attack_step) && $stable(decay_step));
  endproperty
  a_step_steady: assert property (p_step_steady)
    else $error("step changed without a word clock");
endmodule

// *** verif/test_drct_timing_ctrl.sv ***
// Self-checking bench for the compressor timing control block
`timescale 1ns/1ns
module test_drct_timing_ctrl;
  import drct_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, word_clk, er, ok, right_seen;
  logic left_hold_start, right_hold_start, pready, pslverr, sample_tick;
  logic left_comp_en, right_comp_en, left_hold_active, right_hold_active;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, a, d, pa, pd;
  logic [7:0] rd, en;
  logic [STEP_W-1:0] attack_step, decay_step;
  logic [HOLD_W-1:0] len;
  int n_mismatch, n_tests, tick_cnt, k;

  drct_timing_ctrl drct_timing_ctrl_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .word_clk(word_clk),
    .left_hold_start(left_hold_start), .right_hold_start(right_hold_start),
    .left_comp_en(left_comp_en), .right_comp_en(right_comp_en),
    .left_hold_active(left_hold_active),
    .right_hold_active(right_hold_active), .attack_step(attack_step),
    .decay_step(decay_step), .sample_tick(sample_tick));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [HOLD_W-1:0] hold_len(input logic [3:0] c);
    if (c == 4'h0) return '0;
    if (c <= 4'hB) return 18'h00020 << (c - 4'h1);
    if (c == 4'hC) return 18'h10000;
    if (c == 4'hD) return 18'h18000;
    return 18'h28000;
  endfunction

  function automatic logic [31:0] att_exp(input logic [3:0] c);
    return {8'h00, 24'h800000 >> c};
  endfunction

  function automatic logic [31:0] dec_exp(input logic [3:0] c);
    return {8'h00, 24'h008000 >> c};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h want %h", $time, msg, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [7:0] wd, input logic [3:0] st);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h000000, wd};
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Word clock kept at 3 pclk high, 3 low
  task automatic wclk(input int n);
    repeat (n) begin
      @(posedge pclk);
      word_clk <= 1'b1;
      repeat (3) @(posedge pclk);
      word_clk <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask

  task automatic end_sim;
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    if (sample_tick === 1'b1 && left_hold_active === 1'b1)
      tick_cnt <= tick_cnt + 1;
    if (right_hold_active === 1'b1)
      right_seen <= 1'b1;
  end

  // Longest run is a few thousand cycles
  initial begin
    #300000;
    n_mismatch++;
    end_sim;
  end

  initial begin
    {psel, penable, pwrite, word_clk, left_hold_start} = 5'h00;
    right_hold_start = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    presetn = 1'b0;
    {n_mismatch, n_tests, tick_cnt} = 0;
    right_seen = 1'b0;
    k = $urandom(16477);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    check(attack_step, 32'h800000, "attack reset");
    check(decay_step, 32'h008000, "decay reset");
    apb(1'b0, ADDR_ENABLE, 8'h00, 4'hF);
    check(rd, 8'h00, "enable reset");
    apb(1'b0, ADDR_HOLD, 8'h00, 4'hF);
    check(rd, 8'h38, "hold reset");
    apb(1'b0, 12'h200, 8'h00, 4'hF);
    check(er, 1'b1, "unmapped error");
    apb(1'b1, ADDR_STATUS, 8'h07, 4'hF);
    check(er, 1'b1, "status write error");
    k = $urandom_range(15, 0);
    {pa, pd} = 8'h00;
    for (int i = 0; i < 16; i++) begin
      a = 4'(i);
      d = 4'(i + k);
      apb(1'b1, ADDR_RATE, {a, d}, 4'hF);
      check(attack_step, att_exp(pa), "attack before tick");
      wclk(2);
      check(attack_step, att_exp(a), "attack step");
      check(decay_step, dec_exp(d), "decay step");
      apb(1'b0, ADDR_RATE, 8'h00, 4'hF);
      check(rd, {a, d}, "rate readback");
      {pa, pd} = {a, d};
    end
    apb(1'b1, ADDR_RATE, 8'h5A, 4'hE);
    apb(1'b0, ADDR_RATE, 8'h00, 4'hF);
    check(rd, {pa, pd}, "write without strobe");
    for (int i = 0; i < 4; i++) begin
      en = 8'(i) << 5;
      apb(1'b1, ADDR_ENABLE, en, 4'hF);
      repeat (2) @(posedge pclk);
      check(left_comp_en, en[6], "left enable");
      check(right_comp_en, en[5], "right enable");
    end
    apb(1'b1, ADDR_ENABLE, 8'h40, 4'hF);
    for (int c = 0; c < 5; c++) begin
      len = hold_len(c == 4 ? 4'hC : 4'(c));
      apb(1'b1, ADDR_HOLD, {1'b0, (c == 4 ? 4'hC : 4'(c)), 3'b000}, 4'hF);
      tick_cnt = 0;
      @(posedge pclk);
      left_hold_start <= 1'b1;
      right_hold_start <= 1'b1;
      @(posedge pclk);
      left_hold_start <= 1'b0;
      right_hold_start <= 1'b0;
      wclk(2);
      apb(1'b0, ADDR_STATUS, 8'h00, 4'hF);
      check(rd[0], len != 0, "status hold");
      check(rd[1], 1'b0, "status right hold");
      if (c == 4) begin
        wclk(40);
        check(left_hold_active, 1'b1, "long hold");
      end else begin
        wclk(int'(len) + 3);
        ok = (len == 0) ? (tick_cnt == 0) :
             (tick_cnt + 1 >= len && tick_cnt <= len + 1);
        check(ok, 1'b1, "hold length");
      end
    end
    // Upper codes are checked by register readback; code 12 also by the long hold above
    for (int c = 8; c < 16; c++) begin
      apb(1'b1, ADDR_HOLD, {1'b0, 4'(c), 3'b000}, 4'hF);
      repeat (2) @(posedge pclk);
      apb(1'b0, ADDR_HOLD, 8'h00, 4'hF);
      check(rd, {1'b0, 4'(c), 3'b000}, "hold code");
    end
    apb(1'b1, ADDR_ENABLE, 8'h00, 4'hF);
    repeat (3) @(posedge pclk);
    check(left_hold_active, 1'b0, "hold cleared");
    check(right_seen, 1'b0, "right hold disabled");
    // Reset in mid run restores defaults
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    check(attack_step, 32'h800000, "attack after reset");
    check(decay_step, 32'h008000, "decay after reset");
    apb(1'b0, ADDR_HOLD, 8'h00, 4'hF);
    check(rd, 8'h38, "hold after reset");
    apb(1'b0, ADDR_RATE, 8'h00, 4'hF);
    check(rd, 8'h00, "rate after reset");
    end_sim;
  end
endmodule
